// File: msc_pkg.sv
// Notes on behaviour
// - Late timing captures one edge later
// - Data out low once disabled, holds level
// - Polarity bit zero gives active-low selects
// - Loopback off uses external data input
// - Rank field seven means lowest level eight
// - Without continue, last frame stops channel
// - Clock polarity zero idles clock low
// - Phase one: shift odd, sample even
// - Bit order zero sends MSB first
// - Idle level zero keeps select inactive
// - Gap bit zero skips per-frame idle unless release or job end
// - Release bit frees select after frames
// - Parity choice zero is odd parity
// - Baud equals clock over 4^p*div*2
// - Trigger select zero ignores hardware trigger
// - Lead delay is field times clock period
// - Negation delay is field times period
// - Next-frame time is field times period
// - Frame count sets frames per activation
// - Job end after frame frees bus
// - Route bits pick which selects assert
// - Length 0x20 gives 32-bit frames
// - Frame-end pulse after last frame
package msc_pkg;

	localparam int unsigned DATA_W = 32;
	localparam int unsigned LEN_W  = 6;
	localparam int unsigned EDGE_W = 7;
	localparam int unsigned DLY_W  = 12;
	localparam int unsigned CNT_W  = 16;
	localparam int unsigned CS_N   = 8;
	localparam int unsigned DIV_W  = 18;
	localparam int unsigned STAY_W = 13;

	localparam logic [LEN_W-1:0]  LEN_FULL       = 6'h20;
	localparam logic [3:0]        RANK_LEVEL_RST = 4'h8;
	localparam logic [1:0]        REST_LOW       = 2'h1;
	localparam logic [1:0]        REST_HIGH      = 2'h2;
	localparam logic [1:0]        TRIG_SW_ONLY   = 2'h0;
	localparam logic [DATA_W-1:0] WORD_RST       = 32'h0000_0000;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_LEAD  = 3'b001,
		ST_SHIFT = 3'b010,
		ST_HOLD  = 3'b011,
		ST_GAP   = 3'b100
	} msc_state_type;

endpackage

// File: msc_buf2.sv
`timescale 1ns/1ps
module msc_buf2 #(
	parameter int unsigned WIDTH = 32
) (
	input  wire logic             clk,
	input  wire logic             arst_n,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	// Two slots; head slot feeds the output straight from a flop
	logic [WIDTH-1:0] mem_q [2];
	logic [WIDTH-1:0] mem_d [2];
	logic [1:0]       cnt_q;
	logic [1:0]       cnt_d;
	logic             push;
	logic             pop;
	logic             rdy_q;
	logic             vld_q;

	assign push     = in_valid && (cnt_q != 2'h2);
	assign pop      = out_ready && (cnt_q != 2'h0);
	assign out_data = mem_q[0];
	// Flags kept in flops so the handshake outputs carry no logic
	assign out_valid = vld_q;
	assign in_ready  = rdy_q;

	always_comb begin
		mem_d[0] = mem_q[0];
		mem_d[1] = mem_q[1];
		cnt_d    = cnt_q;
		if (pop) begin
			mem_d[0] = mem_q[1];
		end
		if (push) begin
			if (cnt_q == 2'h0 || (cnt_q == 2'h1 && pop)) begin
				mem_d[0] = in_data;
			end else begin
				mem_d[1] = in_data;
			end
		end
		cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mem_q[0] <= '0;
			mem_q[1] <= '0;
			cnt_q    <= 2'h0;
			rdy_q    <= 1'b1;
			vld_q    <= 1'b0;
		end else begin
			mem_q[0] <= mem_d[0];
			mem_q[1] <= mem_d[1];
			cnt_q    <= cnt_d;
			rdy_q    <= (cnt_d != 2'h2);
			vld_q    <= (cnt_d != 2'h0);
		end
	end

	chk_buf_no_overflow : assert property (@(posedge clk) disable iff (!arst_n)
		cnt_q != 2'h3) else $error("buffer count out of range");

endmodule // msc_buf2

// File: msc_baud_div.sv
`timescale 1ns/1ps
module msc_baud_div (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       run,
	input  wire logic [1:0] exponent,
	input  wire logic [msc_pkg::DLY_W-1:0] divider,
	output logic            tick
);
	logic [msc_pkg::DIV_W-1:0] cnt_q;
	logic [msc_pkg::DIV_W-1:0] cnt_d;
	logic [msc_pkg::DIV_W-1:0] half;
	logic                      tick_q;
	logic                      tick_d;

	assign half = (divider == '0) ? 18'h0_0001 :
		(msc_pkg::DIV_W'({divider, 6'h00}) >> (6 - 2 * exponent));
	assign tick = tick_q;

	always_comb begin
		cnt_d  = cnt_q + 18'h0_0001;
		tick_d = 1'b0;
		if (!run) begin
			cnt_d = '0;
		end else if (cnt_q >= half - 18'h0_0001) begin
			cnt_d  = '0;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d && run;
		end
	end

	logic [msc_pkg::DIV_W-1:0] since_q;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			since_q <= '0;
		end else begin
			if (!run) begin
				since_q <= '0;
			end else begin
				since_q <= tick_q ? 18'h0_0001 : since_q + 18'h0_0001;
			end
		end
	end

	chk_tick_spacing : assert property (@(posedge clk) disable iff (!arst_n)
		(run && $past(run) && $stable(divider) && $stable(exponent) && tick_q && since_q > 1)
		|-> since_q == half) else $error("half period mismatch");

endmodule // msc_baud_div

// File: msc_spi_master.sv
`timescale 1ns/1ps
module msc_spi_master (
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	input  wire logic        module_enable,
	input  wire logic        role_select,
	input  wire logic        receive_capture_timing,
	input  wire logic [1:0]  serial_out_rest_level,
	input  wire logic [7:0]  chip_select_polarity,
	input  wire logic        loopback_enable,
	input  wire logic [2:0]  channel_rank,
	input  wire logic        frame_count_continue,
	input  wire logic        clock_polarity,
	input  wire logic        clock_phase,
	input  wire logic        bit_order,
	input  wire logic        idle_select_level,
	input  wire logic        per_frame_gap_enable,
	input  wire logic        chip_select_release,
	input  wire logic [1:0]  odd_even_choice,
	input  wire logic        parity_check_enable,
	input  wire logic [1:0]  clock_prescaler_exponent,
	input  wire logic [11:0] clock_divider,
	input  wire logic [1:0]  hardware_trigger_select,
	input  wire logic        hw_trigger,
	input  wire logic        sw_trigger,
	input  wire logic [11:0] clock_lead_delay,
	input  wire logic [11:0] cs_negate_delay,
	input  wire logic [11:0] interframe_gap,
	input  wire logic [15:0] frame_count,
	input  wire logic        job_continue,
	input  wire logic [7:0]  chip_select_route,
	input  wire logic [5:0]  frame_length,
	input  wire logic [31:0] tx_data,
	input  wire logic        tx_valid,
	output logic             tx_ready,
	output logic      [31:0] rx_data,
	output logic             rx_valid,
	input  wire logic        rx_ready,
	input  wire logic        serial_in,
	output logic             serial_clock_pin,
	output logic             serial_out_pin,
	output logic      [7:0]  chip_select_pin,
	output logic             channel_active,
	output logic             frame_end_irq,
	output logic             parity_error,
	output logic      [3:0]  rank_level
);
	msc_pkg::msc_state_type state_q, state_d;
	logic [31:0] word_q, word_d, acc_q, acc_d, txb_data;
	logic [15:0] frames_q, frames_d;
	logic [11:0] cnt_q, cnt_d;
	logic [6:0]  edge_q, edge_d, e, se, nedge;
	logic [5:0]  len, k;
	logic [7:0]  cs_q, cs_d;
	logic [3:0]  rank_q, rank_d;
	logic        par_q, par_d, rpar_q, rpar_d, act_q, act_d, on_q, on_d;
	logic        sck_q, sck_d, sout_q, sout_d, push_q, push_d, fe_q, fe_d;
	logic        perr_q, perr_d, txb_valid, txb_pop, rxb_ready, tick, late;
	logic        par_on, go, trig, last, rel, rxbit, cpha0_pre, step;

	msc_buf2 #(.WIDTH(msc_pkg::DATA_W)) u_tx_buf (
		.clk       (ref_clk),
		.arst_n    (arst_n),
		.in_data   (tx_data),
		.in_valid  (tx_valid),
		.in_ready  (tx_ready),
		.out_data  (txb_data),
		.out_valid (txb_valid),
		.out_ready (txb_pop)
	);

	// Receiver stall blocks the next frame start; with no gap a frame can start before the last push lands and lose a word
	msc_buf2 #(.WIDTH(msc_pkg::DATA_W)) u_rx_buf (
		.clk       (ref_clk),
		.arst_n    (arst_n),
		.in_data   (acc_q),
		.in_valid  (push_q),
		.in_ready  (rxb_ready),
		.out_data  (rx_data),
		.out_valid (rx_valid),
		.out_ready (rx_ready)
	);

	msc_baud_div u_div (
		.clk      (ref_clk),
		.arst_n   (arst_n),
		// Starts with the lead's last cycle, so edge two follows edge one by a half period
		.run      (state_d == msc_pkg::ST_SHIFT),
		.exponent (clock_prescaler_exponent),
		.divider  (clock_divider),
		.tick     (tick)
	);

	function automatic logic [11:0] dly(input logic [11:0] v);
		dly = (v == 12'h000) ? 12'h001 : v;
	endfunction

	function automatic logic [4:0] pos(input logic [5:0] kk, input logic [5:0] ln,
		input logic lsb);
		logic [5:0] p;
		p   = lsb ? kk : ln - 6'h01 - kk;
		pos = p[4:0];
	endfunction

	assign len    = (frame_length == 6'h00) ? msc_pkg::LEN_FULL : frame_length;
	// parity appended unless choice says none
	assign par_on = !odd_even_choice[1];
	assign nedge  = {len, 1'b0} + {5'h00, par_on, 1'b0};
	assign late   = receive_capture_timing;
	assign e      = edge_q + 7'h01;
	// capture point moves one edge later
	assign se     = late ? edge_q : e;
	assign k      = 6'(se - 7'h01 >> 1);
	assign rxbit  = loopback_enable ? sout_q : serial_in;
	assign trig   = sw_trigger ||
		(hardware_trigger_select != msc_pkg::TRIG_SW_ONLY && hw_trigger);
	assign go     = act_q && txb_valid && rxb_ready;
	assign last   = (frames_q <= 16'h0001);
	// release after frame or job end
	assign rel    = chip_select_release || !job_continue;
	assign cpha0_pre = !clock_phase;
	assign step   = (state_q == msc_pkg::ST_SHIFT && tick) ||
		(state_q == msc_pkg::ST_LEAD && cnt_q == 12'h000);

	// ****************************************
	// Frame sequencer
	// ****************************************
	always_comb begin
		state_d = state_q;
		word_d  = word_q;
		acc_d   = acc_q;
		frames_d = frames_q;
		cnt_d   = cnt_q;
		edge_d  = edge_q;
		par_d   = par_q;
		rpar_d  = rpar_q;
		act_d   = act_q;
		on_d    = on_q;
		sck_d   = sck_q;
		sout_d  = sout_q;
		push_d  = 1'b0;
		fe_d    = 1'b0;
		perr_d  = 1'b0;
		txb_pop = 1'b0;
		if (trig && !act_q && !role_select) begin
			act_d    = 1'b1;
			frames_d = frame_count;
		end
		case (state_q)
			msc_pkg::ST_IDLE: begin
				if (go) begin
					txb_pop = 1'b1;
					word_d  = txb_data & (32'hFFFF_FFFF >> (6'h20 - len));
					par_d   = odd_even_choice[0] ? ^word_d : ~^word_d;
					acc_d   = msc_pkg::WORD_RST;
					edge_d  = '0;
					// lead delay before first clock edge
					cnt_d   = dly(clock_lead_delay) - 12'h001;
					state_d = on_q ? msc_pkg::ST_SHIFT : msc_pkg::ST_LEAD;
					on_d    = 1'b1;
					if (cpha0_pre) begin
						sout_d = word_d[pos(6'h00, len, bit_order)];
					end
				end
			end
			msc_pkg::ST_LEAD: begin
				if (cnt_q == 12'h000) begin
					state_d = msc_pkg::ST_SHIFT;
				end else begin
					cnt_d = cnt_q - 12'h001;
				end
			end
			msc_pkg::ST_SHIFT: begin
				if (tick && e == nedge + {6'h00, late}) begin
					cnt_d   = dly(cs_negate_delay) - 12'h001;
					state_d = msc_pkg::ST_HOLD;
				end
			end
			msc_pkg::ST_HOLD: begin
				if (cnt_q != 12'h000) begin
					cnt_d = cnt_q - 12'h001;
				end else begin
					push_d   = 1'b1;
					perr_d   = parity_check_enable && par_on &&
						(rpar_q != (odd_even_choice[0] ? ^acc_q : ~^acc_q));
					frames_d = frames_q - 16'h0001;
					// idle level keeps select or drops it
					if ((rel || last) && !idle_select_level) begin
						on_d = 1'b0;
					end
					if (last) begin
						fe_d     = 1'b1;
						frames_d = frame_count;
						act_d    = frame_count_continue;
					end
					if (rel || per_frame_gap_enable) begin
						cnt_d   = dly(interframe_gap) - 12'h001;
						state_d = msc_pkg::ST_GAP;
					end else begin
						state_d = msc_pkg::ST_IDLE;
					end
				end
			end
			msc_pkg::ST_GAP: begin
				if (cnt_q == 12'h000) begin
					state_d = msc_pkg::ST_IDLE;
				end else begin
					cnt_d = cnt_q - 12'h001;
				end
			end
			default: begin
				state_d = msc_pkg::ST_IDLE;
			end
		endcase
		// first clock edge closes the lead delay
		if (step) begin
			edge_d = e;
			if (e <= nedge) begin
				sck_d = !sck_q;
			end
			// shift on odd edges for phase one
			if (clock_phase ? e[0] : (!e[0] && e < nedge)) begin
				sout_d = (e[6:1] < len) ? word_q[pos(e[6:1], len, bit_order)] : par_q;
			end
			if (se != 7'h00 && se <= nedge && (clock_phase ? !se[0] : se[0])) begin
				if (k < len) begin
					acc_d[pos(k, len, bit_order)] = rxbit;
				end else begin
					rpar_d = rxbit;
				end
			end
		end
		if (state_d != msc_pkg::ST_SHIFT) begin
			sck_d = clock_polarity;
		end
		if (state_q == msc_pkg::ST_GAP || (state_q == msc_pkg::ST_IDLE && !go)) begin
			if (serial_out_rest_level == msc_pkg::REST_LOW) begin
				sout_d = 1'b0;
			end else if (serial_out_rest_level == msc_pkg::REST_HIGH) begin
				sout_d = 1'b1;
			end
		end
		// Master only; slave role or disable parks state, clock, data out and selects
		if (!module_enable || role_select) begin
			state_d = msc_pkg::ST_IDLE;
			act_d   = 1'b0;
			on_d    = 1'b0;
			sout_d  = 1'b0;
			sck_d   = clock_polarity;
			txb_pop = 1'b0;
		end
		// routed selects at their active level
		cs_d   = ~chip_select_polarity ^ (chip_select_route & {8{on_d}});
		rank_d = {1'b0, channel_rank} + 4'h1;
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q  <= msc_pkg::ST_IDLE;
			word_q   <= msc_pkg::WORD_RST;
			acc_q    <= msc_pkg::WORD_RST;
			frames_q <= '0;
			cnt_q    <= '0;
			edge_q   <= '0;
			par_q    <= 1'b0;
			rpar_q   <= 1'b0;
			act_q    <= 1'b0;
			on_q     <= 1'b0;
			sck_q    <= 1'b0;
			sout_q   <= 1'b0;
			push_q   <= 1'b0;
			fe_q     <= 1'b0;
			perr_q   <= 1'b0;
			cs_q     <= 8'hFF;
			rank_q   <= msc_pkg::RANK_LEVEL_RST;
		end else begin
			state_q  <= state_d;
			word_q   <= word_d;
			acc_q    <= acc_d;
			frames_q <= frames_d;
			cnt_q    <= cnt_d;
			edge_q   <= edge_d;
			par_q    <= par_d;
			rpar_q   <= rpar_d;
			act_q    <= act_d;
			on_q     <= on_d;
			sck_q    <= sck_d;
			sout_q   <= sout_d;
			push_q   <= push_d;
			fe_q     <= fe_d;
			perr_q   <= perr_d;
			cs_q     <= cs_d;
			rank_q   <= rank_d;
		end
	end

	assign serial_clock_pin = sck_q;
	assign serial_out_pin   = sout_q;
	assign chip_select_pin  = cs_q;
	assign channel_active   = act_q;
	assign frame_end_irq    = fe_q;
	assign parity_error     = perr_q;
	assign rank_level       = rank_q;

	// ****************************************
	// Checks
	// ****************************************
	logic [12:0] stay_q;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			stay_q <= 13'h0001;
		end else begin
			stay_q <= (state_d == state_q) ? stay_q + 13'h0001 : 13'h0001;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	sequence s_exit(msc_pkg::msc_state_type st);
		module_enable && state_q == st ##1 module_enable && state_q != st;
	endsequence

	chk_lead_delay_len : assert property (
		s_exit(msc_pkg::ST_LEAD) |-> $past(stay_q) == {1'b0, $past(dly(clock_lead_delay))})
		else $error("lead delay wrong");
	chk_hold_delay_len : assert property (
		s_exit(msc_pkg::ST_HOLD) |-> $past(stay_q) == {1'b0, $past(dly(cs_negate_delay))})
		else $error("negate delay wrong");
	chk_gap_delay_len : assert property (
		s_exit(msc_pkg::ST_GAP) |-> $past(stay_q) == {1'b0, $past(dly(interframe_gap))})
		else $error("gap delay wrong");
	chk_sck_idle_low : assert property (
		state_q != msc_pkg::ST_SHIFT && $past(state_q) != msc_pkg::ST_SHIFT && !clock_polarity
		&& $stable(clock_polarity) |-> !serial_clock_pin) else $error("clock not idle low");
	chk_last_frame_stop : assert property (
		state_q == msc_pkg::ST_HOLD && cnt_q == 12'h000 && last && module_enable
		&& !role_select && !frame_count_continue |=> frame_end_irq && !channel_active)
		else $error("channel not stopped");
	chk_hw_trig_ignored : assert property (
		hardware_trigger_select == msc_pkg::TRIG_SW_ONLY && hw_trigger && !sw_trigger
		&& !channel_active |=> !channel_active) else $error("hardware trigger taken");
	chk_cs_route_low : assert property (
		state_q == msc_pkg::ST_SHIFT && $past(state_q) == msc_pkg::ST_SHIFT
		&& chip_select_route == 8'h01 && chip_select_polarity == 8'h00 && $stable(chip_select_route)
		|-> chip_select_pin == 8'hFE) else $error("select routing wrong");
	chk_sout_disabled : assert property (
		!module_enable |=> !serial_out_pin) else $error("data out not low");
	chk_rank_level : assert property (
		channel_rank == 3'h7 |=> rank_level == 4'h8) else $error("rank level wrong");

endmodule // msc_spi_master

// File: msc_slave_model.sv
`timescale 1ns/1ps
module msc_slave_model (
	input  wire logic        sck,
	input  wire logic        sel_n,
	input  wire logic        mosi,
	input  wire logic [31:0] reply,
	output logic             miso,
	output logic      [32:0] heard,
	output logic      [7:0]  heard_cnt
);
	logic [32:0] shift_q;
	initial begin
		miso = 1'b0;
		heard = '0;
		heard_cnt = '0;
		shift_q = '0;
	end
	always @(negedge sel_n) begin
		shift_q = {reply, ~^reply};
		heard_cnt = '0;
	end
	always @(posedge sck) if (!sel_n) begin
		miso <= #2 shift_q[32];
		shift_q = {shift_q[31:0], 1'b0};
	end
	always @(negedge sck) if (!sel_n) begin
		heard = {heard[31:0], mosi};
		heard_cnt++;
	end
	// Released line must not keep the last bit
	always @(posedge sel_n) miso <= #2 ~miso;
endmodule // msc_slave_model

// File: msc_spi_master_tb.sv
`timescale 1ns/1ps
module msc_spi_master_tb;
	// ****************
	// Stimulus signals
	// ****************
	logic ref_clk = 0, arst_n = 0, module_enable = 1, role_select = 0, receive_capture_timing = 1;
	logic [1:0] serial_out_rest_level = 0, odd_even_choice = 0, clock_prescaler_exponent = 0;
	logic [7:0] chip_select_polarity = 0, chip_select_route = 8'h01;
	logic loopback_enable = 0, frame_count_continue = 0, clock_polarity = 0, clock_phase = 1;
	logic bit_order = 0, idle_select_level = 0, per_frame_gap_enable = 0, chip_select_release = 1;
	logic parity_check_enable = 1, hw_trigger = 0, sw_trigger = 0, job_continue = 0;
	logic tx_valid = 0, rx_ready = 0, serial_in;
	logic [2:0] channel_rank = 3'h7;
	logic [1:0] hardware_trigger_select = 0;
	logic [11:0] clock_divider = 12'h004, clock_lead_delay = 12'h002;
	logic [11:0] cs_negate_delay = 12'h001, interframe_gap = 12'h001;
	logic [15:0] frame_count = 16'h0004;
	logic [5:0] frame_length = 6'h20;
	logic [31:0] tx_data = 0, reply = 0, rx_data;
	logic tx_ready, rx_valid, serial_clock_pin, serial_out_pin, channel_active;
	logic frame_end_irq, parity_error, sck_p = 0, cs_p = 1, seen = 0;
	logic [7:0] chip_select_pin, heard_cnt;
	logic [3:0] rank_level;
	logic [32:0] heard;
	logic [31:0] exp_rx[$], replies[$];
	logic [32:0] exp_tx[$];
	int num_errors = 0, checked = 0, fe_cnt = 0, rel_cnt = 0, cyc = 0, t_cs = 0, t_e = 0;

	always #5 ref_clk = ~ref_clk;

	msc_spi_master msc_spi_master_inst (.ref_clk, .arst_n, .module_enable, .role_select,
		.receive_capture_timing, .serial_out_rest_level, .chip_select_polarity,
		.loopback_enable, .channel_rank, .frame_count_continue, .clock_polarity, .clock_phase,
		.bit_order, .idle_select_level, .per_frame_gap_enable, .chip_select_release,
		.odd_even_choice, .parity_check_enable, .clock_prescaler_exponent, .clock_divider,
		.hardware_trigger_select, .hw_trigger, .sw_trigger, .clock_lead_delay, .cs_negate_delay,
		.interframe_gap, .frame_count, .job_continue, .chip_select_route, .frame_length,
		.tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready, .serial_in,
		.serial_clock_pin, .serial_out_pin, .chip_select_pin, .channel_active, .frame_end_irq,
		.parity_error, .rank_level);

	msc_slave_model msc_slave_model_inst (.sck(serial_clock_pin), .sel_n(chip_select_pin[0]),
		.mosi(serial_out_pin), .reply(reply), .miso(serial_in), .heard(heard),
		.heard_cnt(heard_cnt));

	// ****************
	// Report helpers
	// ****************
	task automatic check(input logic [32:0] got, input logic [32:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t %s seen %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic final_report;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	// ****************
	// Output watcher
	// ****************
	// Receiver stalls at random so the buffer must hold words
	always @(posedge ref_clk) rx_ready <= #1 ($urandom % 4 != 0);

	always @(posedge ref_clk) if (arst_n) begin
		cyc++;
		if (frame_end_irq === 1'b1) fe_cnt++;
		check(parity_error, 0, "parity flag");
		check(chip_select_pin[7:1], 7'h7F, "unused selects");
		if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
			if (exp_rx.size() == 0) check(1, 0, "extra rx word");
			else check(rx_data, exp_rx.pop_front(), "rx word");
		end
		if (cs_p && !chip_select_pin[0]) begin
			t_cs = cyc;
			seen = 0;
			if (replies.size() > 0) reply = replies.pop_front();
		end
		if (!chip_select_pin[0] && serial_clock_pin !== sck_p) begin
			if (!seen) check(cyc - t_cs, clock_lead_delay, "lead delay");
			else check(cyc - t_e, (4 ** clock_prescaler_exponent) * clock_divider, "half");
			seen = 1;
			t_e = cyc;
		end
		if (!cs_p && chip_select_pin[0]) begin
			rel_cnt++;
			if (exp_tx.size() == 0) check(1, 0, "extra frame");
			else check(heard, exp_tx.pop_front(), "tx bits");
			check(heard_cnt, 33, "bit count");
		end
		sck_p = serial_clock_pin;
		cs_p = chip_select_pin[0];
	end

	// ****************
	// Driver tasks
	// ****************
	task automatic send(input logic [31:0] w);
		tx_data = w;
		tx_valid = 1'b1;
		for (int n = 0; n <= 5000; n++) begin
			@(posedge ref_clk);
			if (tx_ready === 1'b1) break;
			if (n == 5000) begin
				num_errors++;
				final_report;
			end
		end
		#1;
	endtask

	task automatic run_job(input logic [1:0] p, input logic [11:0] d, input logic [11:0] ld,
		input logic lb, input logic late);
		logic [31:0] w;
		clock_prescaler_exponent = p;
		clock_divider = d;
		clock_lead_delay = ld;
		loopback_enable = lb;
		receive_capture_timing = late;
		fe_cnt = 0;
		rel_cnt = 0;
		for (int i = 0; i < 4; i++) begin
			w = $urandom;
			replies.push_back(w);
			if (!lb) exp_rx.push_back(w);
		end
		reply = replies.pop_front();
		for (int i = 0; i < 4; i++) begin
			w = $urandom;
			exp_tx.push_back({w, ~^w});
			if (lb) exp_rx.push_back(w);
			send(w);
			if (i == 1) begin
				check(tx_ready, 0, "buffer full");
				hw_trigger = 1'b1;
				repeat (3) @(posedge ref_clk);
				#1 hw_trigger = 1'b0;
				check(channel_active, 0, "hw trigger");
				sw_trigger = 1'b1;
				@(posedge ref_clk);
				#1 sw_trigger = 1'b0;
				@(posedge ref_clk);
				#1 check(channel_active, 1, "sw trigger");
				sw_trigger = 1'b1;
			end
			if (i == 2) sw_trigger = 1'b0;
		end
		tx_valid = 1'b0;
		for (int n = 0; channel_active !== 1'b0 || exp_rx.size() != 0; n++) begin
			@(posedge ref_clk);
			#1;
			if (n == 20000) begin
				num_errors++;
				final_report;
			end
		end
		repeat (4) @(posedge ref_clk);
		#1 check(fe_cnt, 1, "frame end");
		check(rel_cnt, 4, "frames");
		check(channel_active, 0, "active");
		check(serial_clock_pin, 0, "idle clock");
		check(chip_select_pin, 8'hFF, "idle selects");
	endtask

	// ****************
	// Main sequence
	// ****************
	initial begin
		void'($urandom(32'h8d79_92b7));
		repeat (8) @(posedge ref_clk);
		#1 arst_n = 1'b1;
		repeat (2) @(posedge ref_clk);
		#1 check(serial_clock_pin, 0, "rest clock");
		check(chip_select_pin, 8'hFF, "rest selects");
		check(serial_out_pin, 0, "rest data");
		for (int r = 0; r < 8; r++) begin
			channel_rank = r[2:0];
			repeat (2) @(posedge ref_clk);
			#1 check(rank_level, r + 1, "rank");
		end
		run_job(2'h0, 12'h004, 12'h002, 1'b0, 1'b1);
		// Disable parks data out low whatever level the last frame left
		module_enable = 1'b0;
		repeat (2) @(posedge ref_clk);
		#1 check(serial_out_pin, 0, "disabled data");
		module_enable = 1'b1;
		run_job(2'h1, 12'h003, 12'h009, 1'b0, 1'b0);
		run_job(2'h0, 12'h001, 12'h005, 1'b1, 1'b1);
		final_report;
	end
endmodule // msc_spi_master_tb
